// file: tc_value_formatter.sv
// eight-channel thermocouple and millivolt value formatter with apb registers
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps

// Functional notes
// - code FFh: channel off, nothing formatted
// - code 11h: D = 27648 * U / 80 mV
// - voltage reported up to 32511 overrange
// - voltage reported down to -32512 underrange
// - B0h..B9h thermocouple, external compensation, nibble type
// - C0h..C9h same types, internal compensation
// - temperature in tenths of selected unit
// - below nominal range gives -32768
// - type J nominal range limits
// - type K nominal range limits
// - type N nominal range limits
// - types R and S nominal range limits
// - type T nominal range limits
// - type B nominal range limits
// - type C nominal range limits
// - type E nominal range limits
// - type L nominal range limits
// - fahrenheit top of B and C is 32756
// - two-bit unit: 00 C, 01 F, 10 K
// - external mode uses per-channel cold-junction reference
module tc_value_formatter
#(
	parameter int CHANNELS = 8
)
(
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               sample_valid,
	input  wire logic [2:0]         sample_channel,
	input  wire logic signed [31:0] sample_value,
	input  wire logic signed [15:0] internal_cj_temp,
	output logic                    result_valid,
	output logic      [2:0]         result_channel,
	output logic      [15:0]        result_value,
	output logic      [7:0]         config_error
);
	import tc_fmt_pkg::*;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic        [1:0]  temperature_unit_select;
	logic        [7:0]  channel_function_code   [CHANNELS];
	logic signed [15:0] cold_junction_reference [CHANNELS];
	logic        [15:0] channel_result          [CHANNELS];
	logic        [7:0]  over_flag;
	logic        [7:0]  under_flag;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic        setup_phase;
	logic        access_phase;
	logic        wr_access;
	logic [2:0]  reg_region;
	logic [2:0]  reg_index;
	logic        aligned;
	logic        hit_unit;
	logic        hit_err;
	logic        hit_status;
	logic        hit_func;
	logic        hit_cj;
	logic        hit_res;
	logic        hit_any;
	logic        idx_ok;
	logic [31:0] next_prdata;

	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access    = access_phase & pwrite;
	assign reg_region   = paddr[7:5];
	assign reg_index    = paddr[4:2];
	assign aligned      = paddr[1:0] == 2'h0;
	assign idx_ok       = 32'(reg_index) < CHANNELS;
	assign hit_unit     = paddr == OFS_UNIT;
	assign hit_err      = paddr == OFS_CFG_ERR;
	assign hit_status   = paddr == OFS_STATUS;
	// channel tables repeat every four bytes inside a 32-byte region
	assign hit_func     = aligned & idx_ok &
	                      (reg_region == OFS_FUNC_BASE[7:5]);
	assign hit_cj       = aligned & idx_ok &
	                      (reg_region == OFS_CJ_BASE[7:5]);
	assign hit_res      = aligned & idx_ok &
	                      (reg_region == OFS_RES_BASE[7:5]);
	assign hit_any      = hit_unit | hit_err | hit_status |
	                      hit_func | hit_cj | hit_res;

	// zero wait states: read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~hit_any;

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_unit) begin
			next_prdata = {30'h0, temperature_unit_select};
		end else if (hit_err) begin
			next_prdata = {24'h0, config_error};
		end else if (hit_status) begin
			next_prdata = {16'h0, under_flag, over_flag};
		end else if (hit_func) begin
			next_prdata = {24'h0, channel_function_code[reg_index]};
		end else if (hit_cj) begin
			next_prdata = {16'h0, cold_junction_reference[reg_index]};
		end else if (hit_res) begin
			next_prdata = {16'h0, channel_result[reg_index]};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------
	// channel mode decode
	// ------------------------------------------------------------
	logic [7:0]  code;
	logic [3:0]  tc_type;
	logic        is_off;
	logic        is_volt;
	logic        is_ext;
	logic        is_int;
	logic        is_tc;
	logic [1:0]  unit_idx;

	assign code     = channel_function_code[sample_channel];
	assign tc_type  = code[3:0];
	assign is_off   = code == FN_OFF;
	assign is_volt  = code == FN_VOLT;
	assign is_ext   = (code[7:4] == FN_TC_EXT) &&
	                  (32'(tc_type) < TC_TYPES);
	assign is_int   = (code[7:4] == FN_TC_INT) &&
	                  (32'(tc_type) < TC_TYPES);
	assign is_tc    = is_ext | is_int;
	// reserved unit code 11 falls back to celsius
	assign unit_idx = (temperature_unit_select == 2'h3) ?
	                  UNIT_C : temperature_unit_select;

	// ------------------------------------------------------------
	// configuration check
	// ------------------------------------------------------------
	logic [7:0] next_function_code [CHANNELS];
	logic [7:0] next_config_error;

	// the flag is decoded from the code that the coming edge stores, so
	// the registered output moves in the same edge as the function code
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			next_function_code[i] = channel_function_code[i];
		end
		if (wr_access && hit_func) begin
			next_function_code[reg_index] = pwdata[7:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_err
			logic [7:0] c;
			assign c = next_function_code[g];
			assign next_config_error[g] =
				!((c == FN_OFF) || (c == FN_VOLT) ||
				  (((c[7:4] == FN_TC_EXT) || (c[7:4] == FN_TC_INT)) &&
				   (32'(c[3:0]) < TC_TYPES)));
		end
		for (g = CHANNELS; g < 8; g++) begin : g_pad
			assign next_config_error[g] = 1'b0;
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			config_error <= 8'h00;
		end else begin
			config_error <= next_config_error;
		end
	end

	// ------------------------------------------------------------
	// voltage scaling
	// ------------------------------------------------------------
	logic signed [47:0] volt_prod;
	logic signed [47:0] volt_quot;

	// wide product so a full-scale microvolt input cannot wrap
	assign volt_prod = 48'(sample_value) * 48'(VOLT_NOM_CODE);
	assign volt_quot = volt_prod / 48'(VOLT_FS_UV);

	// ------------------------------------------------------------
	// cold-junction compensation and unit conversion
	// ------------------------------------------------------------
	logic signed [31:0] cj_ref;
	logic signed [31:0] cj_ext_c;
	logic signed [31:0] cj_c;
	logic signed [31:0] hot_c;
	logic signed [31:0] hot_unit;

	// sign-extend so a negative reference survives the unit arithmetic
	assign cj_ref = 32'(cold_junction_reference[sample_channel]);

	// the reference is held in the selected unit, the sum is done in celsius
	always_comb begin
		unique case (unit_idx)
			UNIT_F:  cj_ext_c = ((cj_ref - F_OFFSET) * 5) / 9;
			UNIT_K:  cj_ext_c = cj_ref - K_OFFSET;
			default: cj_ext_c = cj_ref;
		endcase
	end

	assign cj_c  = is_ext ? cj_ext_c : 32'(internal_cj_temp);
	assign hot_c = sample_value + cj_c;

	always_comb begin
		unique case (unit_idx)
			UNIT_F:  hot_unit = (hot_c * 9) / 5 + F_OFFSET;
			UNIT_K:  hot_unit = hot_c + K_OFFSET;
			default: hot_unit = hot_c;
		endcase
	end

	// ------------------------------------------------------------
	// range limits and saturation
	// ------------------------------------------------------------
	logic [3:0] type_idx;
	clamp_if    clamp_bus ();

	// out-of-table types are clamped against type index 0 but never taken; index kept in bounds
	assign type_idx = is_tc ? tc_type : 4'h0;

	assign clamp_bus.lo    = is_volt ? VOLT_UNR_MIN :
	                         TC_LO[type_idx][unit_idx];
	assign clamp_bus.hi    = is_volt ? VOLT_OVR_MAX :
	                         TC_HI[type_idx][unit_idx];
	assign clamp_bus.value = is_volt ? 32'(volt_quot) : hot_unit;

	range_clamp u_clamp (
		.c (clamp_bus)
	);

	// ------------------------------------------------------------
	// result output
	// ------------------------------------------------------------
	logic take;

	// off and misconfigured channels produce no result at all
	assign take = sample_valid & ~is_off & (is_volt | is_tc);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			result_valid   <= 1'b0;
			result_channel <= 3'h0;
			result_value   <= RES_RESET;
		end else begin
			result_valid <= take;
			if (take) begin
				result_channel <= sample_channel;
				result_value   <= clamp_bus.word;
			end
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	logic [7:0] set_over;
	logic [7:0] set_under;
	logic [7:0] clr_over;
	logic [7:0] clr_under;
	logic       wr_status;

	assign wr_status = wr_access & hit_status;
	assign clr_over  = wr_status ? pwdata[7:0]  : 8'h00;
	assign clr_under = wr_status ? pwdata[15:8] : 8'h00;
	// a saturated sample marks its own channel only
	assign set_over  = (take & clamp_bus.over)  ?
	                   (8'h01 << sample_channel) : 8'h00;
	assign set_under = (take & clamp_bus.under) ?
	                   (8'h01 << sample_channel) : 8'h00;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			temperature_unit_select <= UNIT_RESET;
		end else if (wr_access && hit_unit) begin
			temperature_unit_select <= pwdata[1:0];
		end
	end

	// a new sample in the clearing cycle keeps its flag set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			over_flag  <= 8'h00;
			under_flag <= 8'h00;
		end else begin
			over_flag  <= (over_flag  & ~clr_over)  | set_over;
			under_flag <= (under_flag & ~clr_under) | set_under;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				channel_function_code[i]   <= FUNC_RESET;
				cold_junction_reference[i] <= CJ_RESET;
			end
		end else if (wr_access) begin
			if (hit_func) begin
				channel_function_code[reg_index] <= pwdata[7:0];
			end
			if (hit_cj) begin
				cold_junction_reference[reg_index] <= pwdata[15:0];
			end
		end
	end

	// a function change wipes that channel's stale result unless a sample is taken in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				channel_result[i] <= RES_RESET;
			end
		end else if (take) begin
			channel_result[sample_channel] <= clamp_bus.word;
		end else if (wr_access && hit_func) begin
			channel_result[reg_index] <= RES_RESET;
		end
	end

endmodule

// file: tc_fmt_pkg.sv
// constants, register map and range tables for the thermocouple formatter
package tc_fmt_pkg;

	// ------------------------------------------------------------
	// register map (byte offsets on the apb bus)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_UNIT      = 8'h00;
	localparam logic [7:0] OFS_CFG_ERR   = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_FUNC_BASE = 8'h20;
	localparam logic [7:0] OFS_CJ_BASE   = 8'h40;
	localparam logic [7:0] OFS_RES_BASE  = 8'h60;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0]  FUNC_RESET = 8'hFF;
	localparam logic [15:0] CJ_RESET   = 16'h0000;
	localparam logic [15:0] RES_RESET  = 16'h0000;
	localparam logic [1:0]  UNIT_RESET = 2'h0;

	// ------------------------------------------------------------
	// channel function codes
	// ------------------------------------------------------------
	localparam logic [7:0] FN_OFF    = 8'hFF;
	localparam logic [7:0] FN_VOLT   = 8'h11;
	localparam logic [3:0] FN_TC_EXT = 4'hB;
	localparam logic [3:0] FN_TC_INT = 4'hC;
	localparam int         TC_TYPES  = 10;

	typedef enum logic [1:0] {
		UNIT_C = 2'h0,
		UNIT_F = 2'h1,
		UNIT_K = 2'h2
	} unit_e;

	// ------------------------------------------------------------
	// scaling and limit codes
	// ------------------------------------------------------------
	localparam int VOLT_NOM_CODE = 27648;
	localparam int VOLT_FS_UV    = 80000;
	localparam int VOLT_OVR_MAX  = 32511;
	localparam int VOLT_UNR_MIN  = -32512;
	localparam int CODE_OVF      = 32767;
	localparam int CODE_UNF      = -32768;
	localparam int F_OFFSET      = 320;
	localparam int K_OFFSET      = 2732;

	// nominal ranges, index [type][unit]; type order J K N R S T B C E L
	localparam int TC_LO [TC_TYPES][3] = '{
		'{-2100, -3460,  632}, '{-2700, -4540,    0},
		'{-2700, -4540,    0}, '{ -500,  -580, 2232},
		'{ -500,  -580, 2232}, '{-2700, -4540,   32},
		'{ 1000,  2120, 3732}, '{    0,   320, 2732},
		'{-2700, -4540,    0}, '{-2000, -3280,  732}
	};
	// fahrenheit tops of B and C stop at 32756 so they fit 16 bits
	localparam int TC_HI [TC_TYPES][3] = '{
		'{12000, 21920, 14732}, '{13720, 25016, 16452},
		'{13000, 23720, 15732}, '{17690, 32162, 20422},
		'{17690, 32162, 20422}, '{ 4000,  7520,  6732},
		'{18200, 32756, 20932}, '{23150, 32756, 25882},
		'{10000, 18320, 12732}, '{ 9000, 16520, 11732}
	};

endpackage

// file: clamp_if.sv
// value and limits passed to the range clamp and its answer
`timescale 1ns/10ps
interface clamp_if;
	logic signed [31:0] value;
	logic signed [31:0] lo;
	logic signed [31:0] hi;
	logic        [15:0] word;
	logic               over;
	logic               under;

	modport user  (output value, output lo, output hi,
	               input word, input over, input under);
	modport clamp (input value, input lo, input hi,
	               output word, output over, output under);
endinterface

// file: range_clamp.sv
// saturates a computed value to the overflow and underflow codes
`timescale 1ns/10ps
module range_clamp (
	clamp_if.clamp c
);
	import tc_fmt_pkg::*;

	logic signed [31:0] ovf_word;
	logic signed [31:0] unf_word;

	assign ovf_word = CODE_OVF;
	assign unf_word = CODE_UNF;
	assign c.over   = c.value > c.hi;
	assign c.under  = c.value < c.lo;
	assign c.word   = c.over  ? ovf_word[15:0] :
	                  c.under ? unf_word[15:0] : c.value[15:0];
endmodule

// file: tc_fmt_assertions.sv
// port-level checker for the thermocouple value formatter
`timescale 1ns/10ps
module tc_fmt_checker (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        sample_valid,
	input  wire logic [2:0]  sample_channel,
	input  wire logic        result_valid,
	input  wire logic [2:0]  result_channel,
	input  wire logic [15:0] result_value,
	input  wire logic [7:0]  config_error
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire signed [15:0] res_s = result_value;

	pready_high_a: assert property (pready)
		else $error("pready dropped");
	result_cause_a: assert property (result_valid |->
		$past(sample_valid) && result_channel == $past(sample_channel))
		else $error("result without a sample one cycle before");
	result_hold_a: assert property (!result_valid |->
		$stable(result_value) && $stable(result_channel))
		else $error("result changed without a valid pulse");
	over_code_a: assert property (result_valid &&
		res_s > 16'sd32756 |-> result_value == 16'h7FFF)
		else $error("value above every range is not the overflow code");
	under_code_a: assert property (result_valid &&
		res_s < -16'sd32512 |-> result_value == 16'h8000)
		else $error("value below every range is not the underflow code");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("error response outside an access phase");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata))
		else $error("read data moved outside a read setup");
	cfg_hold_a: assert property (!(psel && penable && pwrite)
		|=> $stable(config_error))
		else $error("configuration error changed without a write");

	cover property (result_valid && result_value == 16'h7FFF);
	cover property (result_valid && result_value == 16'h8000);
	cover property (pslverr);
endmodule

bind tc_value_formatter tc_fmt_checker i_chk (.clk, .arst_n, .psel,
	.penable, .pwrite, .prdata, .pready, .pslverr, .sample_valid,
	.sample_channel, .result_valid, .result_channel, .result_value,
	.config_error);

// file: tc_source.sv
// thermocouple and millivolt source feeding conversion results
`timescale 1ns/10ps
module tc_source (
	input  wire logic          clk,
	output logic               sample_valid,
	output logic [2:0]         sample_channel,
	output logic signed [31:0] sample_value,
	output logic signed [15:0] internal_cj_temp
);
	initial begin
		sample_valid = 1'b0;
		sample_channel = 3'h0;
		sample_value = 32'h0;
		internal_cj_temp = 16'h0;
	end

	// lines are scrambled after the pulse so stale data never looks fresh
	task automatic send(input logic [2:0] ch, input logic signed [31:0] v,
			input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_channel <= ch;
		sample_value <= v;
		@(posedge clk);
		sample_valid <= 1'b0;
		sample_channel <= ~ch;
		sample_value <= ~v;
	endtask

	task automatic set_cj(input logic signed [15:0] v);
		@(posedge clk);
		internal_cj_temp <= v;
	endtask
endmodule

// file: tb.sv
// self-checking bench for the thermocouple value formatter
`timescale 1ns/10ps
module tb;
	import tc_fmt_pkg::*;
	logic               clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic               sample_valid, result_valid, err;
	logic [7:0]         paddr, config_error;
	logic [31:0]        pwdata, prdata, rd;
	logic [2:0]         sample_channel, result_channel;
	logic signed [31:0] sample_value;
	logic signed [15:0] internal_cj_temp;
	logic [15:0]        result_value;
	int                 n_fail, tests_run;
	int uv [8] = '{80000, -80000, 0, 94074, 94075, -94075, -94080, 1000};

	tc_value_formatter #(.CHANNELS(8)) i_dut (.clk, .arst_n, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.sample_valid, .sample_channel, .sample_value, .internal_cj_temp,
		.result_valid, .result_channel, .result_value, .config_error);
	tc_source i_src (.clk, .sample_valid, .sample_channel, .sample_value,
		.internal_cj_temp);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------
	// bus, sample and compare tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_fail++;
			complete_run();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check({31'h0, err}, 32'h0);
		check(rd, e);
	endtask

	task automatic sc(input logic [2:0] ch, input int v, input logic [15:0] e);
		i_src.send(ch, v, 0);
		#1;
		check({12'h0, result_valid, result_channel, result_value},
			{12'h0, 1'b1, ch, e});
	endtask

	task automatic nr(input logic [2:0] ch, input int v);
		i_src.send(ch, v, 1);
		#1;
		check({31'h0, result_valid}, 32'h0);
	endtask

	function automatic logic [15:0] volt(input longint u);
		longint d;
		d = u * 27648 / 80000;
		if (d > 32511) return 16'h7FFF;
		if (d < -32512) return 16'h8000;
		return d[15:0];
	endfunction

	function automatic logic [15:0] temp(input int c, input int t, input int u);
		int v;
		v = (u == 1) ? c * 9 / 5 + 320 : (u == 2) ? c + 2732 : c;
		if (v > TC_HI[t][u]) return 16'h7FFF;
		if (v < TC_LO[t][u]) return 16'h8000;
		return v[15:0];
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int c;
		n_fail = 0;
		tests_run = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		arst_n = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rc(OFS_UNIT, 32'h0);
		for (int i = 0; i < 8; i++) rc(OFS_FUNC_BASE + 8'(4 * i), 32'hFF);
		rc(OFS_CJ_BASE, 32'h0);
		check({24'h0, config_error}, 32'h0);
		nr(3'd0, 1000);
		$display("test reset and off channel done");
		wr(OFS_FUNC_BASE + 8'h04, 32'h11);
		foreach (uv[i]) sc(3'd1, uv[i], volt(uv[i]));
		rc(OFS_RES_BASE + 8'h04, 32'h0159);
		rc(OFS_STATUS, 32'h0202);
		wr(OFS_STATUS, 32'h0002);
		rc(OFS_STATUS, 32'h0200);
		$display("test voltage done");
		for (int u = 0; u < 3; u++) begin
			wr(OFS_UNIT, 32'(u));
			wr(OFS_CJ_BASE + 8'h08, 32'(u == 1 ? 320 : u == 2 ? 2732 : 0));
			for (int e = 0; e < 2; e++) for (int t = 0; t < 10; t++) begin
				wr(OFS_FUNC_BASE + 8'h08,
					{24'h0, e ? FN_TC_INT : FN_TC_EXT, 4'(t)});
				for (int m = 0; m < 4; m++) begin
					c = m < 2 ? TC_LO[t][0] + m - 1 : TC_HI[t][0] + m - 2;
					sc(3'd2, c, temp(c, t, u));
				end
			end
		end
		wr(OFS_FUNC_BASE + 8'h08, 32'hC1);
		sc(3'd2, 13720, 16'h4044);
		sc(3'd2, 13721, 16'h7FFF);
		wr(OFS_UNIT, 32'h1);
		wr(OFS_FUNC_BASE + 8'h08, 32'hC6);
		sc(3'd2, 18020, 16'h7FF4);
		sc(3'd2, 18021, 16'h7FFF);
		wr(OFS_UNIT, 32'h0);
		wr(OFS_FUNC_BASE + 8'h08, 32'hC0);
		sc(3'd2, -2100, 16'hF7CC);
		sc(3'd2, -2101, 16'h8000);
		$display("test thermocouple ranges done");
		wr(OFS_FUNC_BASE + 8'h0C, 32'hB1);
		wr(OFS_CJ_BASE + 8'h0C, 32'd250);
		sc(3'd3, 1000, 16'd1250);
		wr(OFS_UNIT, 32'h1);
		wr(OFS_CJ_BASE + 8'h0C, 32'd770);
		sc(3'd3, 1000, 16'd2570);
		i_src.set_cj(16'sd250);
		wr(OFS_FUNC_BASE + 8'h0C, 32'hC1);
		sc(3'd3, 1000, 16'd2570);
		wr(OFS_UNIT, 32'h3);
		rc(OFS_UNIT, 32'h3);
		sc(3'd3, 1000, 16'd1250);
		rc(OFS_RES_BASE + 8'h0C, 32'h04E2);
		wr(OFS_FUNC_BASE + 8'h0C, 32'hFF);
		rc(OFS_RES_BASE + 8'h0C, 32'h0);
		nr(3'd3, 1000);
		$display("test cold junction done");
		wr(OFS_FUNC_BASE + 8'h10, 32'h12);
		wr(OFS_FUNC_BASE + 8'h14, 32'hBA);
		#1;
		check({24'h0, config_error}, 32'h30);
		rc(OFS_CFG_ERR, 32'h30);
		nr(3'd4, 100);
		apb(1'b0, 8'hFC, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		check({24'h0, config_error}, 32'h0);
		rc(OFS_FUNC_BASE + 8'h04, 32'hFF);
		$display("test errors and second reset done");
		complete_run();
	end
endmodule
